// ### core/match_timer.sv
// sixteen-bit match timer with AXI4-Lite register access
// assumes aclk at 200 MHz, count clocks and pin arrive asynchronous to aclk
`timescale 1ns/1ps
`include "match_timer_regs.svh"

// Functional notes
// - a lone half write leaves the active compare value unchanged, except a high write with the fast clock in SLOW2.
// - comparator keeps old value until high half write, then adopts both halves.
// - control bits 7, 6 and 1 read back undefined; here zero.
// - undivided fast clock allowed only in timer mode during SLOW2.
// - STOP entry clears run request; software must restart afterwards.
// - three modes: timer, event counter, window.
// - timer mode on oscillator clocks can time oscillator warm-up.
// - timer counts selected clock; on match raise interrupt, clear, continue.
// - fast clock in SLOW2 compares upper five bits only.
// - event mode counts pin rising edges; match raises interrupt, clears counter.
// - event mode match check happens on pin falling edge.
// - window mode counts internal clock only while pin high; match clears.
module match_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] count_clock_taps,
    input wire logic count_input_pin,
    output logic match_irq
);
    import match_timer_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        bus_state_t bus;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic rvalid;
        logic aw_got;
        logic w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic run_request;
        mode_t mode;
        logic [2:0] count_clock_select;
        logic [15:0] match_value;
        logic [7:0] low_pending;
        logic low_written;
        logic slow2;
        logic [15:0] count;
        logic [2:0] tap_sync;
        logic [2:0] pin_sync;
        logic tap_level;
        logic pin_level;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic is_match(input logic [15:0] cnt, input logic [15:0] cmp, input logic upper_only);
        if (upper_only) begin
            is_match = cnt[15:`WARM_SHIFT] == cmp[15:`WARM_SHIFT];
        end else begin
            is_match = cnt == cmp;
        end
    endfunction

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] data, input logic en);
        merge_byte = en ? data : old;
    endfunction

    logic wr_go;
    logic upper_only;
    logic tap_rise;
    logic pin_rise;
    logic pin_fall;
    logic stop_req;
    logic hit;
    logic fast_ok;
    logic [7:0] mask_byte;

    always_comb begin
        s_nxt = s_r;
        mask_byte = merge_byte({6'h00, s_r.irq_mask}, s_r.wdata[7:0], s_r.wstrb[0]);
        wr_go = s_r.aw_got && s_r.w_got && s_r.bus == BUS_IDLE;
        // tap 4 is the undivided fast clock
        fast_ok = s_r.count_clock_select != 3'h4 || (s_r.slow2 && s_r.mode == MODE_TIMER);
        upper_only = s_r.count_clock_select == 3'h4 && s_r.slow2;
        // synchroniser: only stages 1 and 2 are compared
        s_nxt.tap_sync = {s_r.tap_sync[1:0], count_clock_taps[s_r.count_clock_select]};
        s_nxt.pin_sync = {s_r.pin_sync[1:0], count_input_pin};
        if (s_r.tap_sync[2] == s_r.tap_sync[1]) begin
            s_nxt.tap_level = s_r.tap_sync[2];
        end
        if (s_r.pin_sync[2] == s_r.pin_sync[1]) begin
            s_nxt.pin_level = s_r.pin_sync[2];
        end
        tap_rise = s_nxt.tap_level && !s_r.tap_level;
        pin_rise = s_nxt.pin_level && !s_r.pin_level;
        pin_fall = !s_nxt.pin_level && s_r.pin_level;
        hit = 1'b0;
        stop_req = 1'b0;

        // ************************************************************
        // bus slave
        // ************************************************************
        s_nxt.irq_status = s_r.irq_status;
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bus = BUS_WRESP;
            s_nxt.resp = 2'h0;
            case ({s_r.awaddr[11:2], 2'h0})
                `OFF_CONTROL: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.run_request = s_r.wdata[`CTL_RUN_BIT];
                        s_nxt.mode = mode_t'(s_r.wdata[`CTL_MODE_LSB +: 2]);
                        s_nxt.count_clock_select = s_r.wdata[`CTL_CLK_LSB +: 3];
                    end
                end
                `OFF_MATCH_LOW: begin
                    // held aside so a lone low write never reaches the comparator
                    if (s_r.wstrb[0]) begin
                        s_nxt.low_pending = s_r.wdata[7:0];
                        s_nxt.low_written = 1'b1;
                    end
                end
                `OFF_MATCH_HIGH: begin
                    if (s_r.wstrb[0] && (s_r.low_written || upper_only)) begin
                        s_nxt.match_value = {s_r.wdata[7:0], upper_only && !s_r.low_written ?
                            s_r.match_value[7:0] : s_r.low_pending};
                        s_nxt.low_written = 1'b0;
                    end
                end
                `OFF_IRQ_MASK: begin
                    s_nxt.irq_mask = mask_byte[1:0];
                end
                `OFF_POWER: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.slow2 = s_r.wdata[`PWR_SLOW2_BIT];
                        stop_req = s_r.wdata[`PWR_STOP_BIT];
                    end
                end
                `OFF_COUNT, `OFF_IRQ_STATUS: begin
                end
                default: begin
                    s_nxt.resp = 2'h2;
                end
            endcase
        end
        if (s_r.bus == BUS_WRESP && s_axi_bready) begin
            s_nxt.bus = BUS_IDLE;
        end
        if (s_r.bus == BUS_IDLE && !wr_go && s_axi_arvalid) begin
            s_nxt.bus = BUS_RRESP;
            s_nxt.resp = 2'h0;
            s_nxt.rdata = 32'h0;
            case ({s_axi_araddr[11:2], 2'h0})
                // bits 7, 6 and 1 are don't-care; zero keeps reads stable
                `OFF_CONTROL: s_nxt.rdata[7:0] = {2'h0, s_r.run_request, s_r.mode, s_r.count_clock_select[2],
                    1'b0, s_r.count_clock_select[0]};
                `OFF_MATCH_LOW: s_nxt.rdata[7:0] = s_r.match_value[7:0];
                `OFF_MATCH_HIGH: s_nxt.rdata[7:0] = s_r.match_value[15:8];
                `OFF_COUNT: s_nxt.rdata[15:0] = s_r.count;
                `OFF_IRQ_STATUS: s_nxt.rdata[1:0] = s_r.irq_status;
                `OFF_IRQ_MASK: s_nxt.rdata[1:0] = s_r.irq_mask;
                `OFF_POWER: s_nxt.rdata[1:0] = {1'b0, s_r.slow2};
                default: s_nxt.resp = 2'h2;
            endcase
        end
        if (s_r.bus == BUS_RRESP && s_axi_rready) begin
            s_nxt.bus = BUS_IDLE;
        end

        // ************************************************************
        // counter
        // ************************************************************
        if (stop_req) begin
            s_nxt.run_request = 1'b0;
        end
        if (!s_r.run_request) begin
            s_nxt.count = 16'h0000;
        end else if (fast_ok) begin
            // fast clock outside timer mode in slow2 freezes the count instead of racing it
            case (s_r.mode)
                MODE_TIMER: begin
                    if (tap_rise && fast_ok) begin
                        if (is_match(s_r.count, s_r.match_value, upper_only)) begin
                            s_nxt.count = 16'h0000;
                            hit = 1'b1;
                        end else begin
                            s_nxt.count = s_r.count + 16'h0001;
                        end
                    end
                end
                MODE_EVENT: begin
                    if (pin_rise) begin
                        s_nxt.count = s_r.count + 16'h0001;
                    end
                    if (pin_fall && is_match(s_r.count, s_r.match_value, 1'b0)) begin
                        s_nxt.count = 16'h0000;
                        hit = 1'b1;
                    end
                end
                MODE_WINDOW: begin
                    if (tap_rise && s_r.pin_level) begin
                        if (is_match(s_r.count, s_r.match_value, 1'b0)) begin
                            s_nxt.count = 16'h0000;
                            hit = 1'b1;
                        end else begin
                            s_nxt.count = s_r.count + 16'h0001;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // ************************************************************
        // interrupts
        // ************************************************************
        if (s_r.bus == BUS_IDLE && !wr_go && s_axi_arvalid && {s_axi_araddr[11:2], 2'h0} == `OFF_IRQ_STATUS) begin
            s_nxt.irq_status = 2'h0;
        end
        // set wins over read-clear
        if (hit) begin
            s_nxt.irq_status[0] = 1'b1;
        end
        if (stop_req && s_r.run_request) begin
            s_nxt.irq_status[1] = 1'b1;
        end
        s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);

        // ************************************************************
        // registered bus handshake outputs
        // ************************************************************
        // taken from the next state so the flops always agree with the live handshake state
        s_nxt.awready = !s_nxt.aw_got;
        s_nxt.wready = !s_nxt.w_got;
        s_nxt.arready = s_nxt.bus == BUS_IDLE && !(s_nxt.aw_got && s_nxt.w_got);
        s_nxt.bvalid = s_nxt.bus == BUS_WRESP;
        s_nxt.rvalid = s_nxt.bus == BUS_RRESP;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.match_value <= `MATCH_RESET;
            s_r.mode <= MODE_TIMER;
            s_r.bus <= BUS_IDLE;
            // ready lines stand high in reset so the first request is taken at once
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.resp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.resp;
    assign match_irq = s_r.irq;

    // ************************************************************
    // checks
    // ************************************************************
    a_stop_clears_run: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_req |=> !s_r.run_request) else $error("stop did not clear run");
    a_idle_counter_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !s_r.run_request |=> s_r.count == 16'h0000) else $error("stopped counter not zero");
    a_hit_sets_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        hit |=> s_r.irq_status[0] && s_r.count == 16'h0000) else $error("match lost");
    a_low_alone_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && {s_r.awaddr[11:2], 2'h0} == `OFF_MATCH_LOW |=> $stable(s_r.match_value))
        else $error("low write changed compare");
    a_high_adopts_both: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && s_r.wstrb[0] && s_r.low_written && {s_r.awaddr[11:2], 2'h0} == `OFF_MATCH_HIGH
        |=> s_r.match_value == {$past(s_r.wdata[7:0]), $past(s_r.low_pending)})
        else $error("compare not adopted");
    a_event_fall_only: assert property (@(posedge aclk) disable iff (!aresetn)
        hit && s_r.mode == MODE_EVENT |-> pin_fall) else $error("event match off fall");
    a_event_rise_count: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.run_request && fast_ok && s_r.mode == MODE_EVENT && pin_rise
        |=> s_r.count == $past(s_r.count) + 16'h0001) else $error("event count missed");
    a_window_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.mode == MODE_WINDOW && !s_r.pin_level && s_r.run_request |=> s_r.count == $past(s_r.count))
        else $error("window counted while low");
    a_fast_timer_only: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.count_clock_select == 3'h4 && !s_r.slow2 && s_r.run_request |=> $stable(s_r.count))
        else $error("fast clock used outside slow2");
    a_upper_bits_match: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.run_request && s_r.mode == MODE_TIMER && upper_only && tap_rise &&
        s_r.count[15:`WARM_SHIFT] == s_r.match_value[15:`WARM_SHIFT] |=> s_r.count == 16'h0000) else $error("upper match missed");
    a_ctl_loose_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && {s_axi_araddr[11:2], 2'h0} == `OFF_CONTROL
        |=> s_r.rdata[7:6] == 2'h0 && !s_r.rdata[1]) else $error("loose control bits not zero");
    a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        match_irq |-> |(s_r.irq_status & s_r.irq_mask)) else $error("irq without cause");
endmodule

// ### core/match_timer_pkg.sv
// types shared by the match timer core
// assumes the register header supplies all numeric constants
package match_timer_pkg;
    typedef enum logic [1:0] {
        MODE_TIMER = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_WINDOW = 2'b10,
        MODE_RSVD = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRESP = 2'b01,
        BUS_RRESP = 2'b10
    } bus_state_t;
endpackage

// ### core/match_timer_regs.svh
// register offsets, field positions, reset values and the warm-up compare shift of the match timer
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef MATCH_TIMER_REGS_SVH
`define MATCH_TIMER_REGS_SVH

`define OFF_CONTROL 12'h000
`define OFF_MATCH_LOW 12'h004
`define OFF_MATCH_HIGH 12'h008
`define OFF_COUNT 12'h00C
`define OFF_IRQ_STATUS 12'h010
`define OFF_IRQ_MASK 12'h014
`define OFF_POWER 12'h018

// control word fields
`define CTL_RUN_BIT 5
`define CTL_MODE_LSB 3
`define CTL_CLK_LSB 0
`define CTL_RESET 8'h00

`define MATCH_RESET 16'hFFFF
`define WARM_SHIFT 11

// power word fields: bit 0 slow2 state, bit 1 stop entry
`define PWR_SLOW2_BIT 0
`define PWR_STOP_BIT 1

`endif

// ### verif/mt_pulse_source.sv
// far-side model: prescaler tap clocks and the external count/window pin
// assumes the bench calls drive_pin from its main sequence, right after a clock edge
`timescale 1ns/1ps
module mt_pulse_source (
    input wire logic aclk,
    output logic [7:0] count_clock_taps,
    output logic count_input_pin
);
    // ************************************************
    // tap clocks and pin driver
    // ************************************************
    // tap 4 stands for the undivided fast clock, so it is the quickest tap
    for (genvar i = 0; i < 8; i++) begin : g_tap
        initial begin
            count_clock_taps[i] = 1'b0;
            forever #(5 * ((i == 4) ? 3 : 4 + i)) count_clock_taps[i] = ~count_clock_taps[i];
        end
    end

    initial count_input_pin = 1'b0;

    task automatic drive_pin(input logic v, input int n);
        int k;
        k = (n < 2) ? 2 : n;
        @(posedge aclk);
        count_input_pin <= v;
        repeat (k - 1) @(posedge aclk);
    endtask
endmodule

// ### verif/tb_sixteen_bit_match_timer.sv
// self-checking bench for the match timer: register table, then timer, event, window, fast clock, stop, reset
// assumes match_timer, its package and register header, and mt_pulse_source are compiled first
`timescale 1ns/1ps
`include "match_timer_regs.svh"
module tb_sixteen_bit_match_timer;
    import match_timer_pkg::*;
    typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] exp; logic [1:0] resp;} row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, pin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] taps;
    int n_fail = 0;
    int cmp_count = 0;
    row_t rows[11] = '{
        '{1'b0, `OFF_CONTROL, 32'h0, 32'h0, 2'h0},
        '{1'b0, `OFF_COUNT, 32'h0, 32'h0, 2'h0},
        '{1'b0, `OFF_MATCH_LOW, 32'h0, 32'hFF, 2'h0},
        '{1'b0, `OFF_MATCH_HIGH, 32'h0, 32'hFF, 2'h0},
        '{1'b1, `OFF_CONTROL, 32'hC6, 32'h0, 2'h0},
        '{1'b0, `OFF_CONTROL, 32'h0, 32'h04, 2'h0},
        '{1'b1, `OFF_CONTROL, 32'h0, 32'h0, 2'h0},
        '{1'b1, `OFF_IRQ_MASK, 32'h1, 32'h0, 2'h0},
        '{1'b0, `OFF_IRQ_MASK, 32'h0, 32'h1, 2'h0},
        '{1'b0, 12'h01C, 32'h0, 32'h0, 2'h2},
        '{1'b1, 12'h01C, 32'h5, 32'h0, 2'h2}};

    match_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_clock_taps(taps),
        .count_input_pin(pin), .match_irq(irq));
    mt_pulse_source src (.aclk(aclk), .count_clock_taps(taps), .count_input_pin(pin));

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // ************************************************
    // checking and bus tasks
    // ************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic give_up;
        chk(32'h0, 32'h1);
        close_out;
    endtask

    // handshakes are judged at the falling edge; outputs only move on rising edges
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(negedge aclk);
            aw_hs = awvalid & awready;
            w_hs = wvalid & wready;
            b_hs = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) begin
                bready <= 1'b0;
                break;
            end
        end
        if (i == 100) give_up;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(negedge aclk);
            ar_hs = arvalid & arready;
            r_hs = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) begin
                rready <= 1'b0;
                break;
            end
        end
        if (i == 100) give_up;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d, exp);
    endtask

    task automatic wait_irq(input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(negedge aclk);
            if (irq === 1'b1) break;
        end
        if (n == lim) give_up;
    endtask

    // the interrupt line is looked at mid-cycle, never in the edge that moves it
    task automatic chk_irq(input logic exp);
        @(negedge aclk);
        chk(32'(irq), 32'(exp));
    endtask

    function automatic logic [31:0] ctl(input mode_t m, input logic [2:0] c);
        return {26'h0, 1'b1, m, c};
    endfunction

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        int k, n;
        logic [31:0] d;
        logic [1:0] r;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 11; k++) begin
            if (rows[k].wr) begin
                axi_wr(rows[k].a, rows[k].d, r);
            end else begin
                axi_rd(rows[k].a, d, r);
                chk(d, rows[k].exp);
            end
            chk(32'(r), 32'(rows[k].resp));
        end
        $display("test registers done");
        wr(`OFF_MATCH_LOW, 32'h10);
        wr(`OFF_MATCH_HIGH, 32'h0);
        wr(`OFF_MATCH_LOW, 32'h3);
        rd_chk(`OFF_MATCH_LOW, 32'h10);
        wr(`OFF_CONTROL, ctl(MODE_TIMER, 3'd0));
        wait_irq(400, n);
        chk(32'(n > 110 && n < 170), 32'h1);
        rd_chk(`OFF_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge aclk);
        chk_irq(1'b0);
        wait_irq(400, n);
        chk(32'(n > 90 && n < 170), 32'h1);
        wr(`OFF_IRQ_MASK, 32'h0);
        repeat (3) @(posedge aclk);
        chk_irq(1'b0);
        rd_chk(`OFF_IRQ_STATUS, 32'h1);
        wr(`OFF_IRQ_MASK, 32'h1);
        wr(`OFF_CONTROL, 32'h0);
        rd_chk(`OFF_COUNT, 32'h0);
        wr(`OFF_MATCH_HIGH, 32'h0);
        wr(`OFF_CONTROL, ctl(MODE_TIMER, 3'd0));
        wait_irq(200, n);
        chk(32'(n >= 20 && n <= 48), 32'h1);
        rd_chk(`OFF_IRQ_STATUS, 32'h1);
        $display("test timer done");
        wr(`OFF_CONTROL, 32'h0);
        wr(`OFF_CONTROL, ctl(MODE_EVENT, 3'd0));
        for (k = 0; k < 3; k++) begin
            src.drive_pin(1'b1, 8);
            if (k < 2) src.drive_pin(1'b0, 8);
        end
        rd_chk(`OFF_COUNT, 32'h3);
        chk_irq(1'b0);
        src.drive_pin(1'b0, 10);
        chk_irq(1'b1);
        rd_chk(`OFF_IRQ_STATUS, 32'h1);
        rd_chk(`OFF_COUNT, 32'h0);
        $display("test event done");
        wr(`OFF_CONTROL, 32'h0);
        wr(`OFF_CONTROL, ctl(MODE_WINDOW, 3'd0));
        repeat (60) @(posedge aclk);
        rd_chk(`OFF_COUNT, 32'h0);
        src.drive_pin(1'b1, 2);
        wait_irq(100, n);
        rd_chk(`OFF_IRQ_STATUS, 32'h1);
        src.drive_pin(1'b0, 2);
        wr(`OFF_CONTROL, 32'h0);
        $display("test window done");
        wr(`OFF_POWER, 32'h1);
        wr(`OFF_CONTROL, ctl(MODE_WINDOW, 3'd4));
        src.drive_pin(1'b1, 60);
        rd_chk(`OFF_COUNT, 32'h0);
        src.drive_pin(1'b0, 2);
        // stopped with the fast clock selected, so a lone high write is adopted
        wr(`OFF_CONTROL, 32'h4);
        wr(`OFF_MATCH_HIGH, 32'h10);
        wr(`OFF_CONTROL, ctl(MODE_TIMER, 3'd4));
        wait_irq(27000, n);
        chk(32'(n > 23500 && n < 25500), 32'h1);
        wr(`OFF_POWER, 32'h2);
        rd_chk(`OFF_CONTROL, 32'h04);
        rd_chk(`OFF_IRQ_STATUS, 32'h3);
        rd_chk(`OFF_COUNT, 32'h0);
        $display("test fast clock and stop done");
        wr(`OFF_POWER, 32'h0);
        wr(`OFF_CONTROL, ctl(MODE_TIMER, 3'd0));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`OFF_CONTROL, 32'h0);
        rd_chk(`OFF_COUNT, 32'h0);
        chk_irq(1'b0);
        $display("test reset done");
        close_out;
    end
endmodule
